// ==== bench/rxw_mac_src.sv ====
`timescale 1ns/1ns
// ------------------------------------------------------------
// mac receive byte source
// ------------------------------------------------------------
module rxw_mac_src (
	input  wire logic       sys_clk,    // clock
	input  wire logic       rx_ready,   // byte taken
	output logic            rx_valid,   // byte valid
	output logic      [7:0] rx_data,    // byte
	output logic            rx_last,    // last byte
	output logic      [9:0] rx_stat,    // frame status
	output logic            rx_crc_kept // fcs kept
);
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_last = 1'b0;
		rx_stat = 10'h000;
		rx_crc_kept = 1'b0;
	end
	// byte held until taken; idle lines show the inverse
	task automatic send(input logic [7:0] b[$], input logic [9:0] st,
		input logic crc, input logic slow);
		@(posedge sys_clk);
		rx_stat <= st;
		rx_crc_kept <= crc;
		foreach (b[i]) begin
			rx_valid <= 1'b1;
			rx_data <= b[i];
			rx_last <= (i == b.size() - 1);
			do @(negedge sys_clk); while (rx_ready !== 1'b1);
			@(posedge sys_clk);
			if (slow || i == b.size() - 1) begin
				rx_valid <= 1'b0;
				rx_data <= ~b[i];
				rx_last <= 1'b0;
				@(posedge sys_clk);
			end
		end
		rx_stat <= ~st;
		rx_crc_kept <= ~crc;
	endtask
endmodule

// ==== bench/rxw_writeback_test.sv ====
`timescale 1ns/1ns
module rxw_writeback_test;
	import rxw_pkg::*;
	logic        sys_clk;
	logic        rst_n;
	logic [13:0] reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        rx_valid;
	logic [7:0]  rx_data;
	logic        rx_last;
	logic [9:0]  rx_stat;
	logic        rx_crc_kept;
	logic        rx_ready;
	logic        buf_wr_en;
	logic [31:0] buf_wr_addr;
	logic [7:0]  buf_wr_data;
	int          num_errors;
	int          total_checks;
	int          cyc;
	logic [7:0]  lfsr_r;
	logic [39:0] exp_q[$];

	rxw_writeback rxw_writeback_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_last(rx_last), .rx_stat(rx_stat),
		.rx_crc_kept(rx_crc_kept), .rx_ready(rx_ready),
		.buf_wr_en(buf_wr_en), .buf_wr_addr(buf_wr_addr),
		.buf_wr_data(buf_wr_data));
	rxw_mac_src rxw_mac_src_inst (.sys_clk(sys_clk), .rx_ready(rx_ready),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
		.rx_stat(rx_stat), .rx_crc_kept(rx_crc_kept));

	always #25 sys_clk = ~sys_clk;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [13:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [13:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		v = reg_rdata;
	endtask

	// software prepares a free descriptor
	task automatic setd(input logic [12:0] d, input logic [31:0] lk,
		input logic [31:0] bp, input logic [15:0] cap);
		wr({1'b0, d}, lk);
		wr({1'b0, d} + 14'h4, bp);
		wr({1'b0, d} + 14'h8, {16'h0000, cap});
		wr({1'b0, d} + 14'hC, 32'h2000_0000);
	endtask

	task automatic chkd(input logic [12:0] d, input logic [31:0] lk,
		input logic [31:0] bp, input logic [31:0] w2, input logic [31:0] w3);
		logic [31:0] v;
		rd({1'b0, d}, v);
		chk(v, lk);
		rd({1'b0, d} + 14'h4, v);
		chk(v, bp);
		rd({1'b0, d} + 14'h8, v);
		chk(v, w2);
		rd({1'b0, d} + 14'hC, v);
		chk(v, w3);
	endtask

	// core keeps touching memory while the engine writes back
	task automatic widle;
		logic [31:0] s;
		logic [31:0] m;
		s = 32'h1;
		for (int k = 0; k < 200 && s[SB_ACT] !== 1'b0; k++) begin
			rd(14'h0000, m);
			rd(REG_STAT, s);
		end
	endtask

	task automatic frm(input logic [12:0] d, input int n,
		input logic [9:0] st, input logic crc, input logic [15:0] sk);
		logic [7:0]  b[$];
		logic [31:0] bp;
		logic [31:0] v;
		bp = {19'h0, d} + 32'h4000;
		setd(d, 32'h0, bp, 16'h0010);
		wr(REG_SKIP, {16'h0000, sk});
		wr(REG_HEAD, {19'h0, d});
		for (int i = 0; i < n; i++) begin
			lfsr_r = lfsr_next(lfsr_r);
			b.push_back(lfsr_r);
			exp_q.push_back({bp + sk + i, lfsr_r});
		end
		rxw_mac_src_inst.send(b, st, crc, lfsr_r[0]);
		widle();
		chkd(d, 32'h0, bp, {sk, 16'(n)}, {5'b11010, crc, st, 16'(n)});
		rd(REG_STAT, v);
		chk(v, 32'h0000_0002);
	endtask

	// ------------------------------------------------------------
	// store monitor and timeout
	// ------------------------------------------------------------
	always @(negedge sys_clk) begin
		if (buf_wr_en === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk(buf_wr_addr, 32'hFFFF_FFFF);
			end else begin
				chk(buf_wr_addr, exp_q[0][39:8]);
				chk({24'h0, buf_wr_data}, {24'h0, exp_q[0][7:0]});
				void'(exp_q.pop_front());
			end
		end
	end

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors++;
			complete_run();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] v;
		logic [7:0]  b[$];
		logic [13:0] ra[5];
		logic [9:0]  st_t[4];
		sys_clk = 1'b0;
		rst_n = 1'b0;
		reg_addr = 14'h0000;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		cyc = 0;
		num_errors = 0;
		total_checks = 0;
		lfsr_r = 8'h1C;
		ra = '{REG_SKIP, REG_FILT, REG_HEAD, REG_STAT, 14'h2014};
		st_t = '{10'h38E, 10'h040, 10'h020, 10'h001};
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		foreach (ra[i]) begin
			rd(ra[i], v);
			chk(v, 32'h0);
		end
		$display("test reset done");
		wr(REG_FILT, 32'h0);
		lfsr_r = lfsr_next(lfsr_r);
		frm(13'h1FF0, 1 + lfsr_r % 8, 10'h000, 1'b1, 16'(1 + lfsr_r % 3));
		$display("test single done");
		for (int k = 0; k < 4; k++) begin
			wr(REG_FILT, 32'h1 << k);
			frm(13'h0100 + 13'(k * 16), 4, st_t[k], 1'b0, 16'h0000);
		end
		$display("test filters done");
		wr(REG_FILT, 32'h0);
		setd(13'h0040, 32'h50, 32'h2000, 16'h0004);
		setd(13'h0050, 32'h0, 32'h3000, 16'h0010);
		wr(REG_SKIP, 32'h1);
		wr(REG_HEAD, 32'h40);
		for (int i = 0; i < 6; i++) begin
			lfsr_r = lfsr_next(lfsr_r);
			b.push_back(lfsr_r);
			exp_q.push_back({(i < 3) ? 32'h2001 + i : 32'h3000 + i - 3,
				lfsr_r});
		end
		rxw_mac_src_inst.send(b, 10'h000, 1'b0, 1'b1);
		widle();
		chkd(13'h0040, 32'h50, 32'h2000, 32'h0001_0003, 32'h8000_0006);
		chkd(13'h0050, 32'h0, 32'h3000, 32'h0000_0003, 32'h7000_0000);
		$display("test fragments done");
		setd(13'h0060, 32'h0, 32'h5000, 16'h0010);
		wr(REG_HEAD, 32'h60);
		b = '{8'h11, 8'h22, 8'h33};
		rxw_mac_src_inst.send(b, 10'h040, 1'b0, 1'b0);
		chkd(13'h0060, 32'h0, 32'h5000, 32'h10, 32'h2000_0000);
		wr(REG_TDOWN, 32'h1);
		widle();
		chkd(13'h0060, 32'h0, 32'h5000, 32'h10, 32'h0800_0000);
		rd(REG_STAT, v);
		chk(v, 32'h0000_0004);
		rxw_mac_src_inst.send(b, 10'h000, 1'b0, 1'b0);
		widle();
		chk(32'(exp_q.size()), 32'h0);
		$display("test teardown done");
		setd(13'h0070, 32'h0, 32'h6000, 16'h0004);
		wr(REG_HEAD, 32'h70);
		b = '{8'h44, 8'h55, 8'h66, 8'h77, 8'h88};
		for (int i = 0; i < 3; i++)
			exp_q.push_back({32'h6001 + i, b[i]});
		rxw_mac_src_inst.send(b, 10'h000, 1'b0, 1'b0);
		widle();
		chkd(13'h0070, 32'h0, 32'h6000, 32'h0001_0003, 32'hD010_0003);
		rd(REG_STAT, v);
		chk(v, 32'h0000_0002);
		$display("test overrun done");
		complete_run();
	end
endmodule

// ==== hw/rxw_pkg.sv ====
package rxw_pkg;

	// ----------------------------------------------------------------
	// memory and bus map
	// ----------------------------------------------------------------
	localparam int          MEM_BYTES  = 8192;
	localparam int          DESC_BYTES = 16;
	localparam int          BUS_AW     = 14;
	localparam int          MEM_AW     = 13;
	localparam logic [13:0] MEM_TOP    = 14'h2000;
	localparam logic [13:0] REG_SKIP   = 14'h2000;
	localparam logic [13:0] REG_FILT   = 14'h2004;
	localparam logic [13:0] REG_HEAD   = 14'h2008;
	localparam logic [13:0] REG_TDOWN  = 14'h200C;
	localparam logic [13:0] REG_STAT   = 14'h2010;

	// ----------------------------------------------------------------
	// descriptor layout
	// ----------------------------------------------------------------
	localparam logic [12:0] W_LINK = 13'h0000;
	localparam logic [12:0] W_BUF  = 13'h0004;
	localparam logic [12:0] W_LEN  = 13'h0008;
	localparam logic [12:0] W_FLG  = 13'h000C;
	localparam int FLG_SOP  = 31;
	localparam int FLG_EOP  = 30;
	localparam int FLG_OWN  = 29;
	localparam int FLG_EOQ  = 28;
	localparam int FLG_TDN  = 27;
	localparam int FLG_CRC  = 26;
	localparam int FLG_STAT = 16;
	localparam int OFF_LSB  = 16;
	localparam int NSTAT    = 10;

	// ----------------------------------------------------------------
	// receive status bits, same order as descriptor bits 25..16
	// ----------------------------------------------------------------
	localparam int SX_JAB = 9;
	localparam int SX_OVS = 8;
	localparam int SX_FRG = 7;
	localparam int SX_UND = 6;
	localparam int SX_CTL = 5;
	localparam int SX_OVR = 4;
	localparam int SX_COD = 3;
	localparam int SX_ALN = 2;
	localparam int SX_CRC = 1;
	localparam int SX_NOM = 0;

	// ----------------------------------------------------------------
	// receive_filter_enables and status register bits
	// ----------------------------------------------------------------
	localparam int FE_ERR   = 0;
	localparam int FE_SHORT = 1;
	localparam int FE_CTRL  = 2;
	localparam int FE_ALL   = 3;
	localparam int SB_ACT   = 0;
	localparam int SB_EOQ   = 1;
	localparam int SB_TDN   = 2;
	localparam logic [15:0] SKIP_RST = 16'h0000;
	localparam logic [3:0]  FILT_RST = 4'h0;

	typedef enum logic [10:0] {
		ST_IDLE    = 11'h001,
		ST_RD_LINK = 11'h002,
		ST_RD_BUF  = 11'h004,
		ST_RD_LEN  = 11'h008,
		ST_WAIT    = 11'h010,
		ST_STORE   = 11'h020,
		ST_DROP    = 11'h040,
		ST_WB_LEN  = 11'h080,
		ST_WB_EOP  = 11'h100,
		ST_WB_SOP  = 11'h200,
		ST_TDOWN   = 11'h400
	} rxw_state_type;

endpackage

// ==== hw/rxw_writeback.sv ====
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
module rxw_writeback
	import rxw_pkg::*;
#(
	parameter int DEPTH = MEM_BYTES / 4
) (
	input  wire logic        sys_clk,     // 20 MHz clock
	input  wire logic        rst_n,       // async reset
	input  wire logic [13:0] reg_addr,    // byte address
	input  wire logic [31:0] reg_wdata,   // write data
	input  wire logic        reg_wr,      // write strobe
	input  wire logic        reg_rd,      // read strobe
	output logic      [31:0] reg_rdata,   // read data, next cycle
	input  wire logic        rx_valid,    // mac byte valid
	input  wire logic [7:0]  rx_data,     // mac byte
	input  wire logic        rx_last,     // last byte of frame
	input  wire logic [9:0]  rx_stat,     // frame status
	input  wire logic        rx_crc_kept, // frame holds its fcs
	output logic             rx_ready,    // byte taken
	output logic             buf_wr_en,   // buffer byte write
	output logic      [31:0] buf_wr_addr, // buffer byte address
	output logic      [7:0]  buf_wr_data  // buffer byte
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [31:0]        mem [DEPTH];
	rxw_state_type      state_r, state_nxt;
	logic [15:0]        skip_r, skip_nxt;
	logic [3:0]         filt_r, filt_nxt;
	logic [12:0]        cur_r, cur_nxt;
	logic [12:0]        sop_r, sop_nxt;
	logic [12:0]        link_r, link_nxt;
	logic [31:0]        bptr_r, bptr_nxt;
	logic [31:0]        w2_r, w2_nxt;
	logic [15:0]        off_r, off_nxt;
	logic [15:0]        cnt_r, cnt_nxt;
	logic [15:0]        pkt_r, pkt_nxt;
	logic [NSTAT-1:0]   stat_r, stat_nxt;
	logic               crck_r, crck_nxt;
	logic               in_pkt_r, in_pkt_nxt;
	logic               last_r, last_nxt;
	logic               mid_r, mid_nxt;
	logic               tdreq_r, tdreq_nxt;
	logic               eoq_r, eoq_nxt;
	logic               tdn_r, tdn_nxt;
	logic [31:0]        rdata_nxt;
	logic               ready_nxt;
	logic               wen_nxt;
	logic [31:0]        waddr_nxt;
	logic [7:0]         wdata_nxt;

	logic               cpu_mem, cpu_hit, grant, take, keep, err;
	logic               eng_we, mem_we;
	logic [12:0]        eng_off, eng_base, eng_addr;
	logic [10:0]        mem_wa;
	logic [31:0]        mem_wd, eng_q, w3;

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt  = state_r;
		skip_nxt   = skip_r;
		filt_nxt   = filt_r;
		cur_nxt    = cur_r;
		sop_nxt    = sop_r;
		link_nxt   = link_r;
		bptr_nxt   = bptr_r;
		w2_nxt     = w2_r;
		off_nxt    = off_r;
		cnt_nxt    = cnt_r;
		pkt_nxt    = pkt_r;
		stat_nxt   = stat_r;
		crck_nxt   = crck_r;
		in_pkt_nxt = in_pkt_r;
		last_nxt   = last_r;
		tdreq_nxt  = tdreq_r;
		eoq_nxt    = eoq_r;
		tdn_nxt    = tdn_r;
		wen_nxt    = 1'b0;
		waddr_nxt  = buf_wr_addr;
		wdata_nxt  = buf_wr_data;
		rdata_nxt  = 32'h0000_0000;
		eng_we     = 1'b0;
		w3         = 32'h0000_0000;

		// core port always wins the memory; engine waits a cycle
		cpu_mem = reg_addr < MEM_TOP;
		cpu_hit = (reg_wr | reg_rd) & cpu_mem;
		grant   = !cpu_hit;
		take    = rx_valid & rx_ready;
		mid_nxt = take ? !rx_last : mid_r;

		case (state_r)
			ST_RD_LINK: eng_off = W_LINK;
			ST_RD_BUF:  eng_off = W_BUF;
			ST_RD_LEN,
			ST_WB_LEN:  eng_off = W_LEN;
			default:    eng_off = W_FLG;
		endcase
		eng_base = (state_r == ST_WB_SOP) ? sop_r : cur_r;
		eng_addr = eng_base + eng_off;
		eng_q    = mem[eng_addr[12:2]];

		err = rx_stat[SX_JAB] | rx_stat[SX_OVS] | rx_stat[SX_FRG]
		    | rx_stat[SX_COD] | rx_stat[SX_ALN] | rx_stat[SX_CRC];
		keep = !(err && !filt_r[FE_ERR])
		    && !(rx_stat[SX_UND] && !filt_r[FE_SHORT])
		    && !(rx_stat[SX_CTL] && !filt_r[FE_CTRL])
		    && !(rx_stat[SX_NOM] && !filt_r[FE_ALL]);

		if (reg_rd) begin
			case (reg_addr)
				REG_SKIP: rdata_nxt = {16'h0000, skip_r};
				REG_FILT: rdata_nxt = {28'h0000000, filt_r};
				REG_HEAD: rdata_nxt = {19'h00000, cur_r};
				REG_STAT: rdata_nxt = {29'h00000000, tdn_r, eoq_r,
					state_r != ST_IDLE};
				default:  rdata_nxt = cpu_mem ?
					mem[reg_addr[12:2]] : 32'h0000_0000;
			endcase
		end
		if (reg_wr && reg_addr == REG_SKIP)
			skip_nxt = reg_wdata[15:0];
		if (reg_wr && reg_addr == REG_FILT)
			filt_nxt = reg_wdata[3:0];
		if (reg_wr && reg_addr == REG_TDOWN && reg_wdata[0])
			tdreq_nxt = 1'b1;

		case (state_r)
			ST_IDLE: begin
				if (tdreq_r) begin
					tdreq_nxt = 1'b0;
					tdn_nxt   = 1'b1;
				end else if (reg_wr && reg_addr == REG_HEAD) begin
					cur_nxt   = reg_wdata[12:0];
					eoq_nxt   = 1'b0;
					tdn_nxt   = 1'b0;
					state_nxt = ST_RD_LINK;
				end
			end
			ST_RD_LINK: if (grant) begin
				link_nxt  = eng_q[12:0];
				state_nxt = ST_RD_BUF;
			end
			ST_RD_BUF: if (grant) begin
				bptr_nxt  = eng_q;
				state_nxt = ST_RD_LEN;
			end
			ST_RD_LEN: if (grant) begin
				w2_nxt    = eng_q;
				cnt_nxt   = 16'h0000;
				off_nxt   = in_pkt_r ? 16'h0000 : skip_r;
				state_nxt = in_pkt_r ? ST_STORE : ST_WAIT;
			end
			ST_WAIT: begin
				if (tdreq_r) begin
					state_nxt = ST_TDOWN;
				end else if (rx_valid) begin
					stat_nxt = rx_stat;
					crck_nxt = rx_crc_kept;
					if (keep && !mid_r) begin
						in_pkt_nxt = 1'b1;
						sop_nxt    = cur_r;
						pkt_nxt    = 16'h0000;
						state_nxt  = ST_STORE;
					end else begin
						state_nxt = ST_DROP;
					end
				end
			end
			ST_STORE: if (take) begin
				wen_nxt   = 1'b1;
				waddr_nxt = bptr_r + {16'h0000, off_r}
				          + {16'h0000, cnt_r};
				wdata_nxt = rx_data;
				cnt_nxt   = cnt_r + 16'h0001;
				pkt_nxt   = pkt_r + 16'h0001;
				stat_nxt[SX_OVR] = stat_r[SX_OVR] | rx_stat[SX_OVR];
				if (rx_last) begin
					last_nxt  = 1'b1;
					state_nxt = ST_WB_LEN;
				end else if (cnt_r + 16'h0001 == w2_r[15:0] - off_r) begin
					state_nxt = ST_WB_LEN;
				end
			end
			ST_DROP: if (take && rx_last) begin
				state_nxt = ST_WAIT;
			end
			ST_WB_LEN: if (grant) begin
				eng_we = 1'b1;
				w3 = {(cur_r == sop_r) ? off_r : w2_r[31:16], cnt_r};
				if (last_r || link_r == 13'h0000) begin
					// out of buffers mid-frame: close it as overrun
					if (!last_r)
						stat_nxt[SX_OVR] = 1'b1;
					last_nxt  = 1'b1;
					state_nxt = (cur_r == sop_r) ? ST_WB_SOP : ST_WB_EOP;
				end else begin
					cur_nxt   = link_r;
					state_nxt = ST_RD_LINK;
				end
			end
			ST_WB_EOP: if (grant) begin
				eng_we = 1'b1;
				w3[FLG_OWN] = 1'b1;
				w3[FLG_EOP] = 1'b1;
				w3[FLG_EOQ] = link_r == 13'h0000;
				state_nxt = ST_WB_SOP;
			end
			ST_WB_SOP: if (grant) begin
				// hardware_owns_flag released last, after every other write-back
				eng_we = 1'b1;
				w3[FLG_SOP] = 1'b1;
				w3[FLG_EOP] = cur_r == sop_r;
				w3[FLG_EOQ] = cur_r == sop_r && link_r == 13'h0000;
				w3[FLG_CRC] = crck_r;
				w3[FLG_STAT +: NSTAT] = stat_r;
				w3[15:0] = pkt_r;
				in_pkt_nxt = 1'b0;
				last_nxt   = 1'b0;
				if (link_r == 13'h0000) begin
					eoq_nxt   = 1'b1;
					state_nxt = ST_IDLE;
				end else begin
					cur_nxt   = link_r;
					state_nxt = ST_RD_LINK;
				end
			end
			ST_TDOWN: if (grant) begin
				eng_we       = 1'b1;
				w3[FLG_TDN]  = 1'b1;
				tdreq_nxt    = 1'b0;
				tdn_nxt      = 1'b1;
				state_nxt    = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase

		// halted channel drops frames so the mac never stalls
		ready_nxt = state_nxt == ST_STORE || state_nxt == ST_DROP
		         || state_nxt == ST_IDLE;
		if (take && state_nxt == ST_STORE && state_r == ST_STORE
		    && (rx_last || cnt_nxt == w2_r[15:0] - off_r))
			ready_nxt = 1'b0;

		mem_we = eng_we | (reg_wr & cpu_mem);
		mem_wa = eng_we ? eng_addr[12:2] : reg_addr[12:2];
		mem_wd = eng_we ? w3 : reg_wdata;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r     <= ST_IDLE;
			skip_r      <= SKIP_RST;
			filt_r      <= FILT_RST;
			cur_r       <= '0;
			sop_r       <= '0;
			link_r      <= '0;
			bptr_r      <= '0;
			w2_r        <= '0;
			off_r       <= '0;
			cnt_r       <= '0;
			pkt_r       <= '0;
			stat_r      <= '0;
			crck_r      <= 1'b0;
			in_pkt_r    <= 1'b0;
			last_r      <= 1'b0;
			mid_r       <= 1'b0;
			tdreq_r     <= 1'b0;
			eoq_r       <= 1'b0;
			tdn_r       <= 1'b0;
			reg_rdata   <= '0;
			rx_ready    <= 1'b0;
			buf_wr_en   <= 1'b0;
			buf_wr_addr <= '0;
			buf_wr_data <= '0;
		end else begin
			state_r     <= state_nxt;
			skip_r      <= skip_nxt;
			filt_r      <= filt_nxt;
			cur_r       <= cur_nxt;
			sop_r       <= sop_nxt;
			link_r      <= link_nxt;
			bptr_r      <= bptr_nxt;
			w2_r        <= w2_nxt;
			off_r       <= off_nxt;
			cnt_r       <= cnt_nxt;
			pkt_r       <= pkt_nxt;
			stat_r      <= stat_nxt;
			crck_r      <= crck_nxt;
			in_pkt_r    <= in_pkt_nxt;
			last_r      <= last_nxt;
			mid_r       <= mid_nxt;
			tdreq_r     <= tdreq_nxt;
			eoq_r       <= eoq_nxt;
			tdn_r       <= tdn_nxt;
			reg_rdata   <= rdata_nxt;
			rx_ready    <= ready_nxt;
			buf_wr_en   <= wen_nxt;
			buf_wr_addr <= waddr_nxt;
			buf_wr_data <= wdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_buf_word_kept: assert property (eng_we |-> eng_off != W_BUF)
		else $error("engine wrote buffer address word");
	a_link_word_kept: assert property (eng_we |-> eng_off != W_LINK)
		else $error("engine wrote link word");
	a_skip_first: assert property (state_r == ST_RD_LEN && grant
		&& !in_pkt_r |=> off_r == $past(skip_r))
		else $error("first fragment offset differs from skip");
	a_skip_later: assert property (state_r == ST_RD_LEN && grant
		&& in_pkt_r |=> off_r == 16'h0000 && state_r == ST_STORE)
		else $error("later fragment got a start skip");
	a_len_back: assert property (eng_we && state_r == ST_WB_LEN
		|-> mem_wd[15:0] == cnt_r)
		else $error("buffer length write-back wrong");
	a_pkt_len: assert property (eng_we && state_r == ST_WB_SOP
		|-> mem_wd[15:0] == pkt_r && mem_wd[FLG_SOP])
		else $error("packet length write-back wrong");
	a_hardware_owns_flag_last: assert property (eng_we && eng_off == W_FLG
		&& !mem_wd[FLG_OWN] |=> state_r == ST_IDLE
		|| state_r == ST_RD_LINK)
		else $error("hardware_owns_flag released before packet closed");
	a_eoq_null: assert property (eng_we && mem_wd[FLG_EOQ]
		|-> link_r == 13'h0000 && mem_wd[FLG_EOP])
		else $error("queue-ended without null link");
	a_eoq_halt: assert property (eng_we && state_r == ST_WB_SOP
		&& link_r == 13'h0000 |=> eoq_r && state_r == ST_IDLE)
		else $error("channel did not halt on null link");
	a_tdown_stop: assert property (state_r == ST_TDOWN && grant
		|=> state_r == ST_IDLE && tdn_r ##1 state_r == ST_IDLE)
		else $error("teardown did not stop queue");
	a_core_first: assert property (cpu_hit |-> !eng_we)
		else $error("engine took memory from core port");
	a_short_drop: assert property (state_r == ST_WAIT && !tdreq_r
		&& rx_valid && rx_stat[SX_UND] && !filt_r[FE_SHORT]
		|=> state_r == ST_DROP)
		else $error("short frame stored while not kept");

	c_multi_frag: cover property (eng_we && state_r == ST_WB_EOP);
	c_single: cover property (eng_we && state_r == ST_WB_SOP
		&& cur_r == sop_r);
	c_teardown: cover property (state_r == ST_TDOWN && grant);
	c_drop: cover property (state_r == ST_DROP && rx_ready && rx_last);

endmodule
